// ==== core/ext_instr_datapath.sv ====
// extended instruction datapath with ahb-lite register access
//
// Contract
// - OR acc with byte, only zero flag
// - rotate left, bit 7 to 0, flags kept
// - acc rotate variants leave memory untouched
// - rotate left through carry, carry only
// - rotate right, bit 0 to 7, flags kept
// - rotate right through carry, carry only
// - subtract with borrow updates six flags
// - carry clear if negative, else set
// - plain subtract, same six flags
// - decrement to memory, skip on zero
// - skip instructions take three cycles
// - decrement into acc, skip on zero
// - increment to memory, skip on zero
// - increment into acc, skip on zero
// - byte set writes all ones, flags kept
// - bit set forces only selected bit
// - bit test skips when bit is one
// - byte test skips when byte nonzero
// - nibble swap in place, no flags
// - acc nibble swap keeps memory, no flags
// - store move copies acc to memory
`timescale 1ns/10ps
`default_nettype none
module ext_instr_datapath #(
  parameter int unsigned AW = 8
) (
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset, low
  input wire logic ce, // clock enable, freezes all
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // response
  output logic [31:0] hrdata, // read data
  output logic mem_wr_stb, // memory byte written
  output logic [7:0] mem_wdata, // memory byte value
  output logic skip_req, // sequencer drops next op
  output logic dummy_cycle, // inserted dummy cycle
  output logic busy // instruction in flight
);
  typedef struct packed {
    ext_dp_pkg::seq_state_t st;
    logic [31:0] rdata;
    logic [7:0] acc;
    logic [5:0] flags;
    logic [7:0] mem;
    logic [4:0] op;
    logic bit_mode;
    logic [2:0] bit_sel;
    logic [7:0] res;
    logic acc_we;
    logic mem_we;
    logic [5:0] flags_new;
    logic sk_class;
    logic sk_cond;
    logic skip_taken;
    logic mem_written;
    logic [2:0] cycles;
    logic mem_stb;
    logic skip_stb;
  } state_t;

  localparam state_t STATE_RESET = '{
    st: ext_dp_pkg::ST_IDLE,
    acc: ext_dp_pkg::ACC_RESET,
    flags: ext_dp_pkg::FLAGS_RESET,
    mem: ext_dp_pkg::MEM_RESET,
    default: '0
  };

  state_t s_reg;
  state_t s_next;
  logic take_rd;
  logic wr_en;
  logic [AW-1:0] wr_addr;

  ext_ahb_front #(
    .AW(AW)
  ) u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .haddr_lo(haddr[AW-1:0]),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .take_rd(take_rd),
    .wr_en(wr_en),
    .wr_addr(wr_addr)
  );

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  function automatic logic [31:0] reg_read(input state_t s,
                                           input logic [AW-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (8'(a))
      ext_dp_pkg::OFF_CMD:
      begin
        v[ext_dp_pkg::CMD_OP_LSB +: ext_dp_pkg::CMD_OP_W] = s.op;
        v[ext_dp_pkg::CMD_BIT_LSB +: 3] = s.bit_sel;
        v[ext_dp_pkg::CMD_MODE_BIT] = s.bit_mode;
      end
      ext_dp_pkg::OFF_ACC: v[7:0] = s.acc;
      ext_dp_pkg::OFF_FLAGS: v[5:0] = s.flags;
      ext_dp_pkg::OFF_MEM: v[7:0] = s.mem;
      ext_dp_pkg::OFF_STATUS:
      begin
        v[ext_dp_pkg::STAT_BUSY] = s.st != ext_dp_pkg::ST_IDLE;
        v[ext_dp_pkg::STAT_SKIP] = s.skip_taken;
        v[ext_dp_pkg::STAT_MEMWR] = s.mem_written;
        v[ext_dp_pkg::STAT_DUMMY] = s.st == ext_dp_pkg::ST_DUMMY;
      end
      ext_dp_pkg::OFF_CYCLES: v[2:0] = s.cycles;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb
  begin
    ext_dp_pkg::op_t op;
    logic [7:0] a;
    logic [7:0] m;
    logic c;
    logic cin;
    logic [8:0] diff;
    logic [4:0] half;
    logic [5:0] sub_f;
    logic [7:0] bmask;
    logic [7:0] r;
    logic [5:0] f;
    logic wa;
    logic wm;
    logic skc;
    logic sk;
    logic [2:0] target;
    op = ext_dp_pkg::op_t'(s_reg.op);
    a = s_reg.acc;
    m = s_reg.mem;
    c = s_reg.flags[ext_dp_pkg::FLAG_C];
    r = 8'h00;
    f = s_reg.flags;
    wa = 1'b0;
    wm = 1'b0;
    skc = 1'b0;
    sk = 1'b0;
    target = ext_dp_pkg::PLAIN_CYCLES;
    bmask = 8'h01 << s_reg.bit_sel;
    // borrow form feeds the carry, plain form feeds a constant one
    cin = (op == ext_dp_pkg::ext_subtract_borrow_to_acc
        || op == ext_dp_pkg::ext_subtract_borrow_to_mem) ? c : 1'b1;
    diff = {1'b0, a} + {1'b0, ~m} + {8'h00, cin};
    half = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin};
    sub_f = s_reg.flags;
    sub_f[ext_dp_pkg::FLAG_C] = diff[8];
    sub_f[ext_dp_pkg::FLAG_AC] = half[4];
    sub_f[ext_dp_pkg::FLAG_Z] = is_zero(diff[7:0]);
    sub_f[ext_dp_pkg::FLAG_OV] = (a[7] ^ m[7]) & (diff[7] ^ a[7]);
    sub_f[ext_dp_pkg::FLAG_SC] = ((a[7] ^ m[7]) & (diff[7] ^ a[7]))
                                 ^ diff[7];
    // the borrow form chains zero across multi-byte subtracts
    sub_f[ext_dp_pkg::FLAG_CZ] = (cin == c && op
        != ext_dp_pkg::ext_subtract_to_acc && op
        != ext_dp_pkg::ext_subtract_to_mem)
        ? (is_zero(diff[7:0]) & s_reg.flags[ext_dp_pkg::FLAG_CZ])
        : is_zero(diff[7:0]);

    unique case (op)
      ext_dp_pkg::ext_or_to_accumulator, ext_dp_pkg::ext_or_to_memory:
      begin
        r = a | m;
        f[ext_dp_pkg::FLAG_Z] = is_zero(r);
        wa = op == ext_dp_pkg::ext_or_to_accumulator;
        wm = op == ext_dp_pkg::ext_or_to_memory;
      end
      ext_dp_pkg::ext_rotate_left, ext_dp_pkg::ext_rotate_left_to_acc:
      begin
        r = {m[6:0], m[7]};
        wa = op == ext_dp_pkg::ext_rotate_left_to_acc;
        wm = !wa;
      end
      ext_dp_pkg::ext_rotate_left_carry,
      ext_dp_pkg::ext_rotate_left_carry_to_acc:
      begin
        r = {m[6:0], c};
        f[ext_dp_pkg::FLAG_C] = m[7];
        wa = op == ext_dp_pkg::ext_rotate_left_carry_to_acc;
        wm = !wa;
      end
      ext_dp_pkg::ext_rotate_right, ext_dp_pkg::ext_rotate_right_to_acc:
      begin
        r = {m[0], m[7:1]};
        wa = op == ext_dp_pkg::ext_rotate_right_to_acc;
        wm = !wa;
      end
      ext_dp_pkg::ext_rotate_right_carry,
      ext_dp_pkg::ext_rotate_right_carry_to_acc:
      begin
        r = {c, m[7:1]};
        f[ext_dp_pkg::FLAG_C] = m[0];
        wa = op == ext_dp_pkg::ext_rotate_right_carry_to_acc;
        wm = !wa;
      end
      ext_dp_pkg::ext_subtract_borrow_to_acc,
      ext_dp_pkg::ext_subtract_borrow_to_mem,
      ext_dp_pkg::ext_subtract_to_acc,
      ext_dp_pkg::ext_subtract_to_mem:
      begin
        r = diff[7:0];
        f = sub_f;
        wa = op == ext_dp_pkg::ext_subtract_borrow_to_acc
          || op == ext_dp_pkg::ext_subtract_to_acc;
        wm = !wa;
      end
      ext_dp_pkg::ext_decrement_skip_zero,
      ext_dp_pkg::ext_decrement_skip_zero_to_acc:
      begin
        r = m - 8'h01;
        wa = op == ext_dp_pkg::ext_decrement_skip_zero_to_acc;
        wm = !wa;
        skc = 1'b1;
        sk = is_zero(r);
      end
      ext_dp_pkg::ext_increment_skip_zero,
      ext_dp_pkg::ext_increment_skip_zero_to_acc:
      begin
        r = m + 8'h01;
        wa = op == ext_dp_pkg::ext_increment_skip_zero_to_acc;
        wm = !wa;
        skc = 1'b1;
        sk = is_zero(r);
      end
      ext_dp_pkg::ext_set_byte_or_bit:
      begin
        r = s_reg.bit_mode ? (m | bmask) : 8'hff;
        wm = 1'b1;
      end
      ext_dp_pkg::ext_skip_nonzero:
      begin
        skc = 1'b1;
        sk = s_reg.bit_mode ? ((m & bmask) != 8'h00) : !is_zero(m);
      end
      ext_dp_pkg::ext_nibble_swap, ext_dp_pkg::ext_nibble_swap_to_acc:
      begin
        r = {m[3:0], m[7:4]};
        wa = op == ext_dp_pkg::ext_nibble_swap_to_acc;
        wm = !wa;
      end
      ext_dp_pkg::ext_move:
      begin
        r = a;
        wm = 1'b1;
      end
      default:
      begin
        // unknown codes run as a two-cycle no-op
        r = 8'h00;
      end
    endcase

    s_next = s_reg;
    s_next.mem_stb = 1'b0;
    s_next.skip_stb = 1'b0;

    unique case (s_reg.st)
      ext_dp_pkg::ST_IDLE:
      begin
        s_next.st = ext_dp_pkg::ST_IDLE;
      end
      ext_dp_pkg::ST_CALC:
      begin
        // operands are frozen, so the result is latched once here
        s_next.res = r;
        s_next.acc_we = wa;
        s_next.mem_we = wm;
        s_next.flags_new = f;
        s_next.sk_class = skc;
        s_next.sk_cond = sk;
        s_next.cycles = s_reg.cycles + 3'h1;
        s_next.st = ext_dp_pkg::ST_COMMIT;
      end
      ext_dp_pkg::ST_COMMIT:
      begin
        if (s_reg.acc_we)
          s_next.acc = s_reg.res;
        if (s_reg.mem_we)
        begin
          s_next.mem = s_reg.res;
          s_next.mem_stb = 1'b1;
          s_next.mem_written = 1'b1;
        end
        s_next.flags = s_reg.flags_new;
        if (s_reg.sk_class && s_reg.sk_cond)
        begin
          s_next.skip_taken = 1'b1;
          s_next.skip_stb = 1'b1;
        end
        s_next.cycles = s_reg.cycles + 3'h1;
        if (s_reg.sk_class)
          target = ext_dp_pkg::SKIP_CYCLES;
        // the dummy cycle covers the fetch of the dropped op
        s_next.st = (s_next.cycles < target) ? ext_dp_pkg::ST_DUMMY
                                             : ext_dp_pkg::ST_IDLE;
      end
      ext_dp_pkg::ST_DUMMY:
      begin
        s_next.cycles = s_reg.cycles + 3'h1;
        s_next.st = ext_dp_pkg::ST_IDLE;
      end
    endcase

    // software writes only land while idle, so no race with commit
    if (wr_en && s_reg.st == ext_dp_pkg::ST_IDLE)
    begin
      case (8'(wr_addr))
        ext_dp_pkg::OFF_CMD:
        begin
          s_next.op = hwdata[ext_dp_pkg::CMD_OP_LSB +: ext_dp_pkg::CMD_OP_W];
          s_next.bit_sel = hwdata[ext_dp_pkg::CMD_BIT_LSB +: 3];
          s_next.bit_mode = hwdata[ext_dp_pkg::CMD_MODE_BIT];
          s_next.skip_taken = 1'b0;
          s_next.mem_written = 1'b0;
          s_next.cycles = 3'h0;
          s_next.st = ext_dp_pkg::ST_CALC;
        end
        ext_dp_pkg::OFF_ACC: s_next.acc = hwdata[7:0];
        ext_dp_pkg::OFF_FLAGS: s_next.flags = hwdata[5:0];
        ext_dp_pkg::OFF_MEM: s_next.mem = hwdata[7:0];
        default: s_next.st = s_reg.st;
      endcase
    end

    // read data taken from the updated copy: a write right before
    // a read of the same register is seen by that read
    if (take_rd)
      s_next.rdata = reg_read(s_next, haddr[AW-1:0]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_reg <= STATE_RESET;
    else if (ce)
      s_reg <= s_next;
  end

  assign hrdata = s_reg.rdata;
  assign mem_wr_stb = s_reg.mem_stb;
  assign mem_wdata = s_reg.mem;
  assign skip_req = s_reg.skip_stb;
  assign dummy_cycle = s_reg.st == ext_dp_pkg::ST_DUMMY;
  assign busy = s_reg.st != ext_dp_pkg::ST_IDLE;
endmodule // ext_instr_datapath
`default_nettype wire

// ==== common/ext_dp_pkg.sv ====
// constants and types shared by the extended instruction datapath
package ext_dp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_MEM = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CYCLES = 8'h14;
  // flag positions inside the flags register
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_AC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_SC = 4;
  localparam int unsigned FLAG_CZ = 5;
  localparam int unsigned FLAGS_W = 6;
  // command register fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_OP_W = 5;
  localparam int unsigned CMD_BIT_LSB = 8;
  localparam int unsigned CMD_MODE_BIT = 12;
  // status register bits
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_SKIP = 1;
  localparam int unsigned STAT_MEMWR = 2;
  localparam int unsigned STAT_DUMMY = 3;
  // values after reset
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [7:0] MEM_RESET = 8'h00;
  // instruction lengths in clock cycles
  localparam logic [2:0] PLAIN_CYCLES = 3'h2;
  localparam logic [2:0] SKIP_CYCLES = 3'h3;
  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [4:0] {
    ext_or_to_accumulator = 5'h00,
    ext_or_to_memory = 5'h01,
    ext_rotate_left = 5'h02,
    ext_rotate_left_to_acc = 5'h03,
    ext_rotate_left_carry = 5'h04,
    ext_rotate_left_carry_to_acc = 5'h05,
    ext_rotate_right = 5'h06,
    ext_rotate_right_to_acc = 5'h07,
    ext_rotate_right_carry = 5'h08,
    ext_rotate_right_carry_to_acc = 5'h09,
    ext_subtract_borrow_to_acc = 5'h0a,
    ext_subtract_borrow_to_mem = 5'h0b,
    ext_subtract_to_acc = 5'h0c,
    ext_subtract_to_mem = 5'h0d,
    ext_decrement_skip_zero = 5'h0e,
    ext_decrement_skip_zero_to_acc = 5'h0f,
    ext_increment_skip_zero = 5'h10,
    ext_increment_skip_zero_to_acc = 5'h11,
    ext_set_byte_or_bit = 5'h12,
    ext_skip_nonzero = 5'h13,
    ext_nibble_swap = 5'h14,
    ext_nibble_swap_to_acc = 5'h15,
    ext_move = 5'h16
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CALC = 2'h1,
    ST_COMMIT = 2'h2,
    ST_DUMMY = 2'h3
  } seq_state_t;
endpackage

// ==== core/ext_ahb_front.sv ====
// ahb-lite address phase capture for the datapath registers
`timescale 1ns/10ps
`default_nettype none
module ext_ahb_front #(
  parameter int unsigned AW = 8
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [AW-1:0] haddr_lo, // decoded address bits
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic hready, // bus ready in
  output logic hreadyout, // never inserts waits
  output logic hresp, // always okay
  output logic take_rd, // read address phase accepted
  output logic wr_en, // write data phase pending
  output logic [AW-1:0] wr_addr // write data phase address
);
  typedef struct packed {
    logic valid;
    logic write;
    logic [AW-1:0] addr;
  } front_t;

  front_t f_reg;
  front_t f_next;
  logic take;

  // only whole-word transfers reach the registers
  assign take = hsel && hready && (hsize == ext_dp_pkg::HSIZE_WORD)
    && (htrans == ext_dp_pkg::HTRANS_NONSEQ
        || htrans == ext_dp_pkg::HTRANS_SEQ);

  always_comb
  begin
    f_next = f_reg;
    f_next.valid = take;
    f_next.write = hwrite;
    f_next.addr = haddr_lo;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      f_reg <= '0;
    else if (ce)
      f_reg <= f_next;
  end

  assign take_rd = take && !hwrite;
  assign wr_en = f_reg.valid && f_reg.write;
  assign wr_addr = f_reg.addr;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // ext_ahb_front
`default_nettype wire

// ==== dv/ext_dp_chk.sv ====
// port assertions for the extended instruction datapath
`timescale 1ns/10ps
`default_nettype none
module ext_dp_chk (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic mem_wr_stb, // byte written
  input wire logic [7:0] mem_wdata, // byte value
  input wire logic skip_req, // skip pulse
  input wire logic dummy_cycle, // dummy cycle
  input wire logic busy // in flight
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence run_seq;
    busy [*2];
  endsequence
  sequence dummy_seq;
    dummy_cycle ##1 (!busy && !dummy_cycle);
  endsequence
  ready_high_a: assert property (hreadyout)
    else $error("ready went low");
  resp_okay_a: assert property (!hresp)
    else $error("error response seen");
  run_length_a: assert property (
    $rose(busy) |-> run_seq ##1 (!busy || dummy_cycle))
    else $error("instruction length wrong");
  dummy_end_a: assert property (dummy_cycle |-> dummy_seq)
    else $error("dummy cycle not single");
  dummy_third_a: assert property (
    $rose(dummy_cycle) |-> busy && $past(busy) && $past(busy, 2))
    else $error("dummy cycle not third");
  skip_in_dummy_a: assert property (skip_req |-> dummy_cycle)
    else $error("skip outside dummy cycle");
  wr_pulse_a: assert property (
    mem_wr_stb |-> $past(busy) ##1 !mem_wr_stb)
    else $error("memory strobe wrong");
  mem_hold_a: assert property (
    busy && $past(busy) && !mem_wr_stb |-> $stable(mem_wdata))
    else $error("memory changed without strobe");
  rdata_hold_a: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data moved");
endmodule // ext_dp_chk
bind ext_instr_datapath ext_dp_chk u_ext_dp_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .mem_wr_stb(mem_wr_stb),
  .mem_wdata(mem_wdata), .skip_req(skip_req),
  .dummy_cycle(dummy_cycle), .busy(busy));
`default_nettype wire

// ==== dv/ext_seq_model.sv ====
// sequencer and memory side model counting skips and byte writes
`timescale 1ns/10ps
`default_nettype none
module ext_seq_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic skip_req, // skip pulse
  input wire logic dummy_cycle, // dummy cycle
  input wire logic mem_wr_stb, // byte written
  input wire logic [7:0] mem_wdata, // byte value
  output logic [7:0] skip_count, // skips taken
  output logic [7:0] wr_count, // byte writes
  output logic [7:0] mem_byte // last byte stored
);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      skip_count <= 8'h00;
      wr_count <= 8'h00;
      mem_byte <= 8'h00;
    end
    else
    begin
      // drop the next fetch only inside the dummy slot
      if (skip_req && dummy_cycle)
        skip_count <= skip_count + 8'h01;
      if (mem_wr_stb)
      begin
        wr_count <= wr_count + 8'h01;
        mem_byte <= mem_wdata;
      end
    end
  end
endmodule // ext_seq_model
`default_nettype wire

// ==== dv/extended_instr_datapath_tb.sv ====
// self-checking bench for the extended instruction datapath
`timescale 1ns/10ps
`default_nettype none
module extended_instr_datapath_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic mem_wr_stb, skip_req, dummy_cycle, busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [7:0] mem_wdata, skip_count, wr_count, mem_byte;
  logic [7:0] va [4] = '{8'h01, 8'h80, 8'h7f, 8'h5a};
  logic [7:0] vm [4] = '{8'h01, 8'hff, 8'h80, 8'h00};
  logic [5:0] vf [4] = '{6'h3f, 6'h00, 6'h20, 6'h01};
  int fails, check_count;
  ext_instr_datapath u_ext_instr_datapath (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mem_wr_stb(mem_wr_stb), .mem_wdata(mem_wdata), .skip_req(skip_req),
    .dummy_cycle(dummy_cycle), .busy(busy));
  ext_seq_model u_ext_seq_model (.hclk(hclk), .hresetn(hresetn),
    .skip_req(skip_req), .dummy_cycle(dummy_cycle),
    .mem_wr_stb(mem_wr_stb), .mem_wdata(mem_wdata),
    .skip_count(skip_count), .wr_count(wr_count), .mem_byte(mem_byte));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered right after a rising edge; returns at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= ext_dp_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    hsize <= ext_dp_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic wait_idle;
    do @(posedge hclk); while (busy !== 1'b0);
  endtask
  task automatic run(input logic [4:0] op, input logic [3:0] bm,
                     input logic [7:0] a, input logic [5:0] f,
                     input logic [7:0] m);
    logic [8:0] d;
    logic [4:0] l;
    logic [7:0] r, s0, w0;
    logic [5:0] ef;
    logic b, sk, mw, cls;
    r = m;
    ef = f;
    sk = 1'b0;
    cls = 1'b0;
    case (op)
      5'h00, 5'h01: r = a | m;
      5'h02, 5'h03: r = {m[6:0], m[7]};
      5'h04, 5'h05:
      begin
        r = {m[6:0], f[ext_dp_pkg::FLAG_C]};
        ef[ext_dp_pkg::FLAG_C] = m[7];
      end
      5'h06, 5'h07: r = {m[0], m[7:1]};
      5'h08, 5'h09:
      begin
        r = {f[ext_dp_pkg::FLAG_C], m[7:1]};
        ef[ext_dp_pkg::FLAG_C] = m[0];
      end
      5'h0a, 5'h0b, 5'h0c, 5'h0d:
      begin
        b = !op[2] && !f[ext_dp_pkg::FLAG_C];
        d = {1'b0, a} - {1'b0, m} - {8'h00, b};
        l = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, b};
        r = d[7:0];
        ef[ext_dp_pkg::FLAG_C] = !d[8];
        ef[ext_dp_pkg::FLAG_AC] = !l[4];
        ef[ext_dp_pkg::FLAG_OV] = (a[7] ^ m[7]) & (r[7] ^ a[7]);
        ef[ext_dp_pkg::FLAG_SC] = ef[ext_dp_pkg::FLAG_OV] ^ r[7];
        ef[ext_dp_pkg::FLAG_CZ] = (r == 8'h00)
                                  && (op[2] || f[ext_dp_pkg::FLAG_CZ]);
      end
      5'h0e, 5'h0f: r = m - 8'h01;
      5'h10, 5'h11: r = m + 8'h01;
      5'h12: r = bm[3] ? m | (8'h01 << bm[2:0]) : 8'hff;
      5'h13: sk = bm[3] ? m[bm[2:0]] : (m != 8'h00);
      5'h14, 5'h15: r = {m[3:0], m[7:4]};
      5'h16: r = a;
      default: r = m;
    endcase
    if (op inside {[5'h0e:5'h11]})
      sk = (r == 8'h00);
    cls = op inside {[5'h0e:5'h11], 5'h13};
    if (op inside {[5'h00:5'h01], [5'h0a:5'h0d]})
      ef[ext_dp_pkg::FLAG_Z] = (r == 8'h00);
    mw = op inside {5'h01, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0b, 5'h0d,
                    5'h0e, 5'h10, 5'h12, 5'h14, 5'h16};
    wr(ext_dp_pkg::OFF_ACC, {24'h000000, a});
    wr(ext_dp_pkg::OFF_FLAGS, {26'h0000000, f});
    wr(ext_dp_pkg::OFF_MEM, {24'h000000, m});
    s0 = skip_count;
    w0 = wr_count;
    wr(ext_dp_pkg::OFF_CMD, {19'h00000, bm[3], 1'b0, bm[2:0], 3'h0, op});
    wait_idle();
    bus(1'b0, ext_dp_pkg::OFF_ACC, 32'h0, x);
    check(x, {24'h000000, (!mw && op inside {[5'h00:5'h15]}
          && op != 5'h13 && op != 5'h12) ? r : a});
    bus(1'b0, ext_dp_pkg::OFF_MEM, 32'h0, x);
    check(x, {24'h000000, mw ? r : m});
    bus(1'b0, ext_dp_pkg::OFF_FLAGS, 32'h0, x);
    check(x, {26'h0000000, ef});
    bus(1'b0, ext_dp_pkg::OFF_STATUS, 32'h0, x);
    check(x, {29'h0, mw, sk, 1'b0});
    bus(1'b0, ext_dp_pkg::OFF_CYCLES, 32'h0, x);
    check(x, {29'h0, cls ? ext_dp_pkg::SKIP_CYCLES
                         : ext_dp_pkg::PLAIN_CYCLES});
    check({24'h000000, skip_count - s0}, {31'h0, sk});
    check({24'h000000, wr_count - w0}, {31'h0, mw});
    if (mw)
      check({24'h000000, mem_byte}, {24'h000000, r});
  endtask
  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    fails = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0, x);
      check(x, 32'h0);
    end
    // read-only and unmapped places must not take writes
    wr(ext_dp_pkg::OFF_STATUS, 32'h0000000f);
    wr(8'h18, 32'h000000a5);
    bus(1'b0, ext_dp_pkg::OFF_STATUS, 32'h0, x);
    check(x, 32'h0);
    bus(1'b0, 8'h18, 32'h0, x);
    check(x, 32'h0);
    for (int op = 0; op < 24; op++)
      for (int k = 0; k < 4; k++)
        run(op == 23 ? 5'h1f : 5'(op), {k[0], 3'(k * 2 + 1)},
            va[k], vf[k], vm[k]);
    // a write landing while the instruction is in flight is dropped
    wr(ext_dp_pkg::OFF_ACC, 32'h00000011);
    wr(ext_dp_pkg::OFF_CMD, 32'h00000013);
    wr(ext_dp_pkg::OFF_ACC, 32'h00000033);
    wait_idle();
    bus(1'b0, ext_dp_pkg::OFF_ACC, 32'h0, x);
    check(x, 32'h00000011);
    end_of_test();
  end
endmodule // extended_instr_datapath_tb
`default_nettype wire
